// ===== hdl/mxac_pkg.sv
// package: commands, mode-register layout, timing counts and address-half mapping
package mxac_pkg;
  localparam int ADDR_W = 20;
  localparam int BANK_W = 4;
  localparam int NBANK = 16;
  localparam int MR_W = 18;
  localparam int MR0_MUX_BIT = 9;
  localparam int MR1_MULTI_BIT = 8;
  localparam int MR1_BL_LSB = 3;
  localparam int MR1_TERM_LSB = 0;
  localparam int TERM_W = 3;
  localparam logic [1:0] BL_2 = 2'h0;
  localparam logic [1:0] BL_4 = 2'h1;
  localparam logic [1:0] BL_8 = 2'h2;
  localparam logic [1:0] SEL_MR0 = 2'h0;
  localparam logic [1:0] SEL_MR1 = 2'h1;
  localparam logic [1:0] SEL_MR2 = 2'h2;
  localparam logic [MR_W-1:0] MR_USED_MASK = 18'h00fff;
  localparam logic [MR_W-1:0] MR_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] AX_OWN_MASK = 20'h66739;
  localparam int MAX_REF_BANKS = 4;
  localparam int CNT_W = 10;
  localparam int MODE_WRITE_GAP_CYC = 12;
  localparam int STABLE_NOP_CYC = 512;
  localparam int ROW_CYCLE_CYC = 8;
  localparam int FOUR_BANK_WINDOW_CYC = 8;
  // ball pairs that trade places about the centre column
  localparam int MIR_N = 9;
  localparam int MIR_A [MIR_N] = '{9, 4, 3, 18, 8, 10, 12, 17, 13};
  localparam int MIR_B [MIR_N] = '{7, 2, 1, 15, 6, 19, 14, 16, 11};

  typedef enum logic [4:0] {
    MXAC_NOP = 5'h01,
    MXAC_READ = 5'h02,
    MXAC_WRITE = 5'h04,
    MXAC_AUTO_REFRESH_CMD = 5'h08,
    MXAC_MRS = 5'h10
  } mxac_cmd_type;

  // an involution: the same call maps balls to functions and back
  function automatic logic [ADDR_W-1:0] mxac_mirror_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    for (int i = 0; i < MIR_N; i++) begin
      r[MIR_A[i]] = a[MIR_B[i]];
      r[MIR_B[i]] = a[MIR_A[i]];
    end
    return r;
  endfunction

  function automatic logic [BANK_W-1:0] mxac_mirror_ba(input logic [BANK_W-1:0] b);
    return {b[2], b[3], b[0], b[1]};
  endfunction

  function automatic logic [NBANK-1:0] mxac_bank_onehot(input logic [BANK_W-1:0] b);
    logic [NBANK-1:0] r;
    r = '0;
    r[b] = 1'b1;
    return r;
  endfunction

  function automatic logic mxac_a18_dropped(input logic x36, input logic [1:0] bl);
    return x36 ? (bl != BL_2) : (bl == BL_8);
  endfunction

  function automatic logic [ADDR_W-1:0] mxac_split_ax(input logic [ADDR_W-1:0] a,
                                                     input logic x36, input logic [1:0] bl);
    logic [ADDR_W-1:0] x;
    x = a & AX_OWN_MASK;
    if (mxac_a18_dropped(x36, bl)) x[18] = 1'b0;
    return x;
  endfunction

  function automatic logic [ADDR_W-1:0] mxac_split_ay(input logic [ADDR_W-1:0] a,
                                                     input logic x36, input logic [1:0] bl);
    logic [ADDR_W-1:0] y;
    y = '0;
    y[3] = a[1];
    y[4] = a[2];
    y[8] = a[6];
    y[9] = a[7];
    y[13] = a[11];
    y[14] = a[12];
    y[17] = a[16];
    y[18] = a[15];
    if (!x36 && bl == BL_2) y[10] = a[19];
    return y;
  endfunction

  function automatic logic [ADDR_W-1:0] mxac_merge(input logic [ADDR_W-1:0] x,
                                                  input logic [ADDR_W-1:0] y,
                                                  input logic x36, input logic [1:0] bl);
    logic [ADDR_W-1:0] m;
    m = mxac_split_ax(x, x36, bl);
    m[1] = y[3];
    m[2] = y[4];
    m[6] = y[8];
    m[7] = y[9];
    m[11] = y[13];
    m[12] = y[14];
    m[16] = y[17];
    m[15] = y[18];
    if (!x36 && bl == BL_2) m[19] = y[10];
    return m;
  endfunction
endpackage

// ===== hdl/mxac_if.sv
// interface: command, address and strap balls between controller and memory
`timescale 1ns/10ps
interface mxac_if;
  logic cs_n;
  logic we_n;
  logic ref_n;
  logic [mxac_pkg::ADDR_W-1:0] addr;
  logic [mxac_pkg::BANK_W-1:0] ba;
  logic mirror_strap;
  modport ctrl(output cs_n, we_n, ref_n, addr, ba, mirror_strap);
  modport device(input cs_n, we_n, ref_n, addr, ba, mirror_strap);
endinterface

// ===== hdl/mxac_device.sv
// memory end: ball decode, address-half capture, mode registers and refresh
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
module mxac_device #(
  parameter bit WIDTH_X36 = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // balls
  mxac_if.device link,
  // completed commands
  output logic cmd_valid,
  output mxac_pkg::mxac_cmd_type cmd_kind,
  output logic [mxac_pkg::ADDR_W-1:0] cmd_addr,
  output logic [mxac_pkg::BANK_W-1:0] cmd_bank,
  output logic latency_start,
  output logic row_cycle_start,
  // refresh
  output logic refresh_fire,
  output logic [mxac_pkg::NBANK-1:0] refresh_banks,
  // mode state
  output logic mux_mode,
  output logic [mxac_pkg::MR_W-1:0] mode_register_zero,
  output logic [mxac_pkg::MR_W-1:0] mode_register_one,
  output logic [mxac_pkg::MR_W-1:0] mode_register_two,
  output logic term_on,
  output logic [mxac_pkg::TERM_W-1:0] termination_value
);
  typedef enum logic [1:0] {DV_IDLE = 2'b01, DV_HALF = 2'b10} mxac_dev_state_type;

  mxac_dev_state_type state_q;
  mxac_pkg::mxac_cmd_type pend_kind_q, pin_kind, done_kind;
  logic [mxac_pkg::ADDR_W-1:0] ax_q, pin_addr, done_addr;
  logic [mxac_pkg::BANK_W-1:0] ba_q, pin_ba, done_ba;
  logic [mxac_pkg::MR_W-1:0] mr0_q, mr1_q, mr2_q;
  logic [1:0] burst;
  logic bref_pend_q, mux_q, mr2_done_q, pin_we_n, pin_ref_n;
  logic multi_en, two_half, bank_pend, done;
  logic cmd_valid_q, lat_q, rc_q, ref_q;
  mxac_pkg::mxac_cmd_type kind_q;
  logic [mxac_pkg::ADDR_W-1:0] addr_q;
  logic [mxac_pkg::BANK_W-1:0] bank_q;
  logic [mxac_pkg::NBANK-1:0] banks_q;
  logic term_on_q;
  logic [mxac_pkg::TERM_W-1:0] term_q;

  always_comb begin
    // strap is static; pins are read through the swap only when it is high
    pin_addr = link.mirror_strap ? mxac_pkg::mxac_mirror_addr(link.addr) : link.addr;
    pin_ba = link.mirror_strap ? mxac_pkg::mxac_mirror_ba(link.ba) : link.ba;
    pin_we_n = link.mirror_strap ? link.ref_n : link.we_n;
    pin_ref_n = link.mirror_strap ? link.we_n : link.ref_n;
    if (link.cs_n) pin_kind = mxac_pkg::MXAC_NOP;
    else begin
      case ({pin_we_n, pin_ref_n})
        2'h3: pin_kind = mxac_pkg::MXAC_READ;
        2'h1: pin_kind = mxac_pkg::MXAC_WRITE;
        2'h2: pin_kind = mxac_pkg::MXAC_AUTO_REFRESH_CMD;
        default: pin_kind = mxac_pkg::MXAC_MRS;
      endcase
    end
    burst = mr1_q[mxac_pkg::MR1_BL_LSB +: 2];
    multi_en = mr1_q[mxac_pkg::MR1_MULTI_BIT];
    two_half = mux_q && (pin_kind == mxac_pkg::MXAC_READ || pin_kind == mxac_pkg::MXAC_WRITE ||
                         pin_kind == mxac_pkg::MXAC_MRS ||
                         (pin_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD && multi_en));
    bank_pend = mux_q && pin_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD && !multi_en;
    done = 1'b0;
    done_kind = pin_kind;
    done_addr = pin_addr;
    done_ba = pin_ba;
    case (state_q)
      DV_IDLE: begin
        if (bref_pend_q) begin
          done = 1'b1;
          done_kind = pend_kind_q;
          done_ba = ba_q;
        end else begin
          done = !mux_q && pin_kind != mxac_pkg::MXAC_NOP;
        end
      end
      DV_HALF: begin
        // second half: whatever command code sits on the balls is ignored
        done = 1'b1;
        done_kind = pend_kind_q;
        done_ba = ba_q;
        done_addr = mxac_pkg::mxac_merge(ax_q, pin_addr, WIDTH_X36, burst);
      end
      default: done = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= DV_IDLE;
      bref_pend_q <= 1'b0;
      pend_kind_q <= mxac_pkg::MXAC_NOP;
      ax_q <= '0;
      ba_q <= '0;
    end else begin
      bref_pend_q <= 1'b0;
      case (state_q)
        DV_IDLE: begin
          // a command may follow a bank refresh on the very next edge
          if (pin_kind != mxac_pkg::MXAC_NOP) begin
            pend_kind_q <= pin_kind;
            ax_q <= pin_addr;
            ba_q <= pin_ba;
            if (two_half) state_q <= DV_HALF;
            bref_pend_q <= bank_pend;
          end
        end
        DV_HALF: state_q <= DV_IDLE;
        default: state_q <= DV_IDLE;
      endcase
    end
  end

  // completed-command and timing reference outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_valid_q <= 1'b0;
      kind_q <= mxac_pkg::MXAC_NOP;
      addr_q <= '0;
      bank_q <= '0;
      lat_q <= 1'b0;
      rc_q <= 1'b0;
      ref_q <= 1'b0;
      banks_q <= '0;
    end else begin
      cmd_valid_q <= done;
      if (done) begin
        kind_q <= done_kind;
        addr_q <= done_addr;
        bank_q <= done_ba;
      end
      lat_q <= done && (done_kind == mxac_pkg::MXAC_READ ||
                        done_kind == mxac_pkg::MXAC_WRITE);
      rc_q <= state_q == DV_IDLE && pin_kind != mxac_pkg::MXAC_NOP &&
              pin_kind != mxac_pkg::MXAC_MRS;
      ref_q <= done && done_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD;
      if (done && done_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD) begin
        banks_q <= multi_en ? done_addr[mxac_pkg::NBANK-1:0]
                            : mxac_pkg::mxac_bank_onehot(done_ba);
      end
    end
  end

  // mode registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mr0_q <= mxac_pkg::MR_RESET;
      mr1_q <= mxac_pkg::MR_RESET;
      mr2_q <= mxac_pkg::MR_RESET;
      mux_q <= 1'b0;
      mr2_done_q <= 1'b0;
    end else if (done && done_kind == mxac_pkg::MXAC_MRS) begin
      case (done_ba[1:0])
        mxac_pkg::SEL_MR0: begin
          mr0_q <= done_addr[mxac_pkg::MR_W-1:0];
          mux_q <= done_addr[mxac_pkg::MR0_MUX_BIT];
        end
        mxac_pkg::SEL_MR1: mr1_q <= done_addr[mxac_pkg::MR_W-1:0];
        mxac_pkg::SEL_MR2: begin
          mr2_q <= done_addr[mxac_pkg::MR_W-1:0];
          mr2_done_q <= 1'b1;
        end
        default: mr2_done_q <= mr2_done_q;
      endcase
    end
  end

  // termination stays off until the third mode register is written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      term_on_q <= 1'b0;
      term_q <= '0;
    end else begin
      term_q <= mr1_q[mxac_pkg::MR1_TERM_LSB +: mxac_pkg::TERM_W];
      term_on_q <= mr2_done_q &&
                   mr1_q[mxac_pkg::MR1_TERM_LSB +: mxac_pkg::TERM_W] != '0;
    end
  end

  assign cmd_valid = cmd_valid_q;
  assign cmd_kind = kind_q;
  assign cmd_addr = addr_q;
  assign cmd_bank = bank_q;
  assign latency_start = lat_q;
  assign row_cycle_start = rc_q;
  assign refresh_fire = ref_q;
  assign refresh_banks = banks_q;
  assign mux_mode = mux_q;
  assign mode_register_zero = mr0_q;
  assign mode_register_one = mr1_q;
  assign mode_register_two = mr2_q;
  assign term_on = term_on_q;
  assign termination_value = term_q;
endmodule // mxac_device

// ===== hdl/mxac_ctrl.sv
// controller end: request acceptance, spacing, address halves and ball drive
`timescale 1ns/10ps
module mxac_ctrl #(
  parameter bit WIDTH_X36 = 1'b0,
  parameter int MODE_WRITE_GAP = mxac_pkg::MODE_WRITE_GAP_CYC,
  parameter int STABLE_NOP = mxac_pkg::STABLE_NOP_CYC,
  parameter int ROW_CYCLE = mxac_pkg::ROW_CYCLE_CYC,
  parameter int FOUR_BANK_WINDOW = mxac_pkg::FOUR_BANK_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire logic mirror_cfg,
  // requests
  input wire logic req_valid,
  input wire mxac_pkg::mxac_cmd_type req_kind,
  input wire logic [mxac_pkg::ADDR_W-1:0] req_addr,
  input wire logic [mxac_pkg::BANK_W-1:0] req_bank,
  // answers
  output logic req_ack,
  output logic req_reject,
  output logic mux_mode,
  // balls
  mxac_if.ctrl link
);
  typedef enum logic [1:0] {C_IDLE = 2'b01, C_SECOND = 2'b10} mxac_ctrl_state_type;

  mxac_ctrl_state_type state_q;
  logic [mxac_pkg::ADDR_W-1:0] ay_q, cmd_addr, nx_addr, addr_q;
  logic [mxac_pkg::BANK_W-1:0] nx_ba, ba_q;
  logic [mxac_pkg::MR_W-1:0] mr_val;
  logic [mxac_pkg::NBANK-1:0] target, busy;
  logic [mxac_pkg::CNT_W-1:0] gap_q, gap_load;
  logic [mxac_pkg::CNT_W-1:0] rc_q [mxac_pkg::NBANK];
  logic [4:0] nbanks;
  logic [1:0] sel, bl_q;
  logic mux_q, multi_q, mr0_done_q, mr1_done_q, mirror_q, ack_q, rej_q;
  logic multi, is_mrs, illegal, bank_busy, can_go, take, refuse;
  logic nx_cs_n, nx_we_n, nx_ref_n, cs_n_q, we_n_q, ref_n_q;

  always_comb begin
    sel = req_bank[1:0];
    is_mrs = req_kind == mxac_pkg::MXAC_MRS;
    multi = req_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD && multi_q;
    mr_val = req_addr[mxac_pkg::MR_W-1:0] & mxac_pkg::MR_USED_MASK;
    if (sel == mxac_pkg::SEL_MR0 && mux_q) mr_val[mxac_pkg::MR0_MUX_BIT] = 1'b1;
    cmd_addr = is_mrs ? {{(mxac_pkg::ADDR_W - mxac_pkg::MR_W){1'b0}}, mr_val} : req_addr;
    case (req_kind)
      mxac_pkg::MXAC_READ, mxac_pkg::MXAC_WRITE: target = mxac_pkg::mxac_bank_onehot(req_bank);
      mxac_pkg::MXAC_AUTO_REFRESH_CMD: target = multi ? req_addr[mxac_pkg::NBANK-1:0]
                                          : mxac_pkg::mxac_bank_onehot(req_bank);
      default: target = '0;
    endcase
    nbanks = '0;
    for (int i = 0; i < mxac_pkg::NBANK; i++) nbanks = nbanks + 5'(target[i]);
    illegal = req_kind == mxac_pkg::MXAC_NOP ||
              (is_mrs && sel == 2'h3) ||
              (is_mrs && sel == mxac_pkg::SEL_MR1 && !mr0_done_q) ||
              (is_mrs && sel == mxac_pkg::SEL_MR2 && !mr1_done_q) ||
              (is_mrs && sel == mxac_pkg::SEL_MR1 && WIDTH_X36 && mux_q &&
               mr_val[mxac_pkg::MR1_BL_LSB +: 2] == mxac_pkg::BL_8) ||
              (multi && (nbanks == 5'h00 || nbanks > 5'(mxac_pkg::MAX_REF_BANKS)));
    bank_busy = |(target & busy);
    // one request per ack or reject: the cycle in which an answer shows never takes
    can_go = req_valid && state_q == C_IDLE && gap_q == '0 && !ack_q && !rej_q;
    take = can_go && !illegal && !bank_busy;
    refuse = can_go && illegal;
    gap_load = '0;
    if (is_mrs && sel == mxac_pkg::SEL_MR0) begin
      gap_load = mxac_pkg::CNT_W'(MODE_WRITE_GAP);
    end else if (is_mrs && sel == mxac_pkg::SEL_MR1) begin
      gap_load = mxac_pkg::CNT_W'(STABLE_NOP);
    end else if (multi && nbanks > 5'h02) begin
      gap_load = mxac_pkg::CNT_W'(FOUR_BANK_WINDOW);
    end
  end

  // next ball values, before mirroring
  always_comb begin
    nx_cs_n = 1'b1;
    nx_we_n = 1'b1;
    nx_ref_n = 1'b1;
    nx_addr = '0;
    nx_ba = '0;
    case (state_q)
      C_IDLE: begin
        if (take) begin
          nx_cs_n = 1'b0;
          nx_we_n = !(req_kind == mxac_pkg::MXAC_WRITE || is_mrs);
          nx_ref_n = !(req_kind == mxac_pkg::MXAC_AUTO_REFRESH_CMD || is_mrs);
          nx_addr = mux_q ? mxac_pkg::mxac_split_ax(cmd_addr, WIDTH_X36, bl_q) : cmd_addr;
          nx_ba = (is_mrs && mux_q) ? {2'h0, sel} : req_bank;
        end
      end
      C_SECOND: begin
        nx_addr = ay_q;
      end
      default: nx_cs_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= C_IDLE;
      ay_q <= '0;
    end else begin
      case (state_q)
        C_IDLE: begin
          // bank refresh needs only the first edge, so it stays single-cycle
          if (take && mux_q && (req_kind != mxac_pkg::MXAC_AUTO_REFRESH_CMD || multi)) begin
            state_q <= C_SECOND;
            ay_q <= mxac_pkg::mxac_split_ay(cmd_addr, WIDTH_X36, bl_q);
          end
        end
        C_SECOND: state_q <= C_IDLE;
        default: state_q <= C_IDLE;
      endcase
    end
  end

  // ball registers; strap and swap come from one flop, but the swap changes one edge after the strap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mirror_q <= 1'b0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ref_n_q <= 1'b1;
      addr_q <= '0;
      ba_q <= '0;
    end else begin
      mirror_q <= mirror_cfg;
      cs_n_q <= nx_cs_n;
      we_n_q <= mirror_q ? nx_ref_n : nx_we_n;
      ref_n_q <= mirror_q ? nx_we_n : nx_ref_n;
      addr_q <= mirror_q ? mxac_pkg::mxac_mirror_addr(nx_addr) : nx_addr;
      ba_q <= mirror_q ? mxac_pkg::mxac_mirror_ba(nx_ba) : nx_ba;
    end
  end

  // mode shadow: what the memory will hold once each write completes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mux_q <= 1'b0;
      multi_q <= 1'b0;
      bl_q <= mxac_pkg::BL_2;
      mr0_done_q <= 1'b0;
      mr1_done_q <= 1'b0;
    end else if (take && is_mrs) begin
      case (sel)
        mxac_pkg::SEL_MR0: begin
          mux_q <= mr_val[mxac_pkg::MR0_MUX_BIT];
          mr0_done_q <= 1'b1;
          mr1_done_q <= 1'b0;
        end
        mxac_pkg::SEL_MR1: begin
          multi_q <= mr_val[mxac_pkg::MR1_MULTI_BIT];
          bl_q <= mr_val[mxac_pkg::MR1_BL_LSB +: 2];
          mr1_done_q <= 1'b1;
        end
        default: mr1_done_q <= mr1_done_q;
      endcase
    end
  end

  // global gap: mode-write spacing and multibank spacing
  always_ff @(posedge clk) begin
    if (!nrst) gap_q <= '0;
    else if (take) gap_q <= gap_load;
    else if (gap_q != '0) gap_q <= gap_q - 1'b1;
  end

  // per-bank row cycle, counted from the first-half edge
  for (genvar b = 0; b < mxac_pkg::NBANK; b++) begin : g_rc
    always_ff @(posedge clk) begin
      if (!nrst) rc_q[b] <= '0;
      else if (take && target[b]) rc_q[b] <= mxac_pkg::CNT_W'(ROW_CYCLE);
      else if (rc_q[b] != '0) rc_q[b] <= rc_q[b] - 1'b1;
    end
    assign busy[b] = rc_q[b] != '0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      ack_q <= take;
      rej_q <= refuse;
    end
  end

  assign req_ack = ack_q;
  assign req_reject = rej_q;
  assign mux_mode = mux_q;
  assign link.cs_n = cs_n_q;
  assign link.we_n = we_n_q;
  assign link.ref_n = ref_n_q;
  assign link.addr = addr_q;
  assign link.ba = ba_q;
  assign link.mirror_strap = mirror_q;
endmodule // mxac_ctrl

// ===== tb/mxac_props.sv
// checker: spacing and mode-write rules seen on the command balls
`timescale 1ns/10ps
module mxac_props #(
  parameter int MODE_WRITE_GAP = 2,
  parameter int STABLE_NOP = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // balls
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [mxac_pkg::ADDR_W-1:0] addr,
  input wire logic [mxac_pkg::BANK_W-1:0] ba,
  input wire logic mirror_strap
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic mux_q;
  logic [mxac_pkg::CNT_W-1:0] gap_q;
  logic [mxac_pkg::CNT_W-1:0] nop_q;
  logic mode_register_write_cmd;
  logic [1:0] sel;
  logic mux_bit;
  // code 00 survives the we/ref swap, so mode writes decode alike with the strap set
  assign mode_register_write_cmd = !cs_n && !we_n && !ref_n;
  assign sel = mirror_strap ? {ba[0], ba[1]} : ba[1:0];
  assign mux_bit = mirror_strap ? addr[7] : addr[9];
  always_ff @(posedge clk) begin
    if (!nrst) mux_q <= 1'b0;
    else if (mode_register_write_cmd && sel == 2'h0) mux_q <= mux_bit;
  end
  // lenient by one cycle: the command's own cycle is counted, so one idle cycle fewer is required between commands
  always_ff @(posedge clk) begin
    if (!nrst) gap_q <= '0;
    else if (mode_register_write_cmd && sel == 2'h0) gap_q <= mxac_pkg::CNT_W'(MODE_WRITE_GAP - 1);
    else if (gap_q != '0) gap_q <= gap_q - 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) nop_q <= '0;
    else if (mode_register_write_cmd && sel == 2'h1) nop_q <= mxac_pkg::CNT_W'(STABLE_NOP - 1);
    else if (nop_q != '0) nop_q <= nop_q - 1'b1;
  end
  property p_mrs_halves;
    mux_q && mode_register_write_cmd |=> cs_n;
  endproperty
  a_mrs_halves: assert property (p_mrs_halves)
    else $error("mode write second half carried a command");
  property p_read_halves;
    mux_q && !cs_n && we_n && ref_n |=> cs_n;
  endproperty
  a_read_halves: assert property (p_read_halves)
    else $error("read second half carried a command");
  property p_upper_banks;
    mux_q && mode_register_write_cmd |-> ba[3:2] == 2'h0;
  endproperty
  a_upper_banks: assert property (p_upper_banks)
    else $error("upper bank balls high during mode write");
  property p_reserved_balls;
    mux_q && mode_register_write_cmd && !mirror_strap |-> addr[19:15] == 5'h00 ##1 addr[19:15] == 5'h00;
  endproperty
  a_reserved_balls: assert property (p_reserved_balls)
    else $error("reserved address balls high during mode write");
  property p_mr0_keeps;
    mux_q && mode_register_write_cmd && sel == 2'h0 |-> mux_bit;
  endproperty
  a_mr0_keeps: assert property (p_mr0_keeps)
    else $error("mode zero rewrite dropped the muxed bit");
  property p_mode_gap;
    gap_q != '0 |-> cs_n;
  endproperty
  a_mode_gap: assert property (p_mode_gap)
    else $error("command inside the mode write gap");
  property p_stable_nop;
    nop_q != '0 |-> cs_n;
  endproperty
  a_stable_nop: assert property (p_stable_nop)
    else $error("command inside the stable idle count");
  property p_strap_idle;
    $changed(mirror_strap) |-> cs_n;
  endproperty
  a_strap_idle: assert property (p_strap_idle)
    else $error("strap changed beside a command");
endmodule // mxac_props

// ===== tb/muxed_address_command_port_tb.sv
// testbench: controller and memory ends joined, requests in, completed commands checked
`timescale 1ns/10ps
module muxed_address_command_port_tb;
  localparam mxac_pkg::mxac_cmd_type RD = mxac_pkg::MXAC_READ;
  localparam mxac_pkg::mxac_cmd_type WR = mxac_pkg::MXAC_WRITE;
  localparam mxac_pkg::mxac_cmd_type RF = mxac_pkg::MXAC_AUTO_REFRESH_CMD;
  localparam mxac_pkg::mxac_cmd_type MS = mxac_pkg::MXAC_MRS;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mirror_cfg = 1'b0;
  logic req_valid = 1'b0;
  mxac_pkg::mxac_cmd_type req_kind = mxac_pkg::MXAC_NOP;
  logic [19:0] req_addr = 20'h00000;
  logic [3:0] req_bank = 4'h0;
  logic req_ack, req_reject, ctrl_mux, cmd_valid, lat_start, row_start, ref_fire, dev_mux;
  logic term_on;
  mxac_pkg::mxac_cmd_type cmd_kind;
  logic [19:0] cmd_addr;
  logic [3:0] cmd_bank;
  logic [15:0] ref_banks;
  logic [17:0] mr0, mr1, mr2;
  logic [2:0] term_val;
  logic [19:0] addrs [4] = '{20'hfffff, 20'h80000, 20'h7ffff, 20'h5a5a5};
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  mxac_if link_if();
  mxac_ctrl #(.MODE_WRITE_GAP(2), .STABLE_NOP(4), .ROW_CYCLE(2), .FOUR_BANK_WINDOW(2))
    mxac_ctrl_i (.clk(clk), .nrst(nrst), .mirror_cfg(mirror_cfg), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_bank(req_bank), .req_ack(req_ack),
    .req_reject(req_reject), .mux_mode(ctrl_mux), .link(link_if));
  mxac_device mxac_device_i (.clk(clk), .nrst(nrst), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_bank(cmd_bank),
    .latency_start(lat_start), .row_cycle_start(row_start), .refresh_fire(ref_fire),
    .refresh_banks(ref_banks), .mux_mode(dev_mux), .mode_register_zero(mr0),
    .mode_register_one(mr1), .mode_register_two(mr2), .term_on(term_on),
    .termination_value(term_val));
  mxac_props mxac_props_i (.clk(clk), .nrst(nrst),
    .cs_n(link_if.cs_n), .we_n(link_if.we_n), .ref_n(link_if.ref_n), .addr(link_if.addr),
    .ba(link_if.ba), .mirror_strap(link_if.mirror_strap));
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // holds the request until ack or reject is sampled, then drops it on that edge
  task automatic send(input mxac_pkg::mxac_cmd_type k, input logic [19:0] a,
                      input logic [3:0] b, input logic rej);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_bank <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ack !== 1'b1 && req_reject !== 1'b1 && n < 1000);
    req_valid <= 1'b0;
    check("answer", 20'(req_ack | req_reject), 20'h1);
    check("reject", 20'(req_reject), 20'(rej));
  endtask
  // dt: cycles from row-cycle start to data-latency start, negative to skip
  task automatic op(input mxac_pkg::mxac_cmd_type k, input logic [19:0] a,
                    input logic [3:0] b, input logic [19:0] ea, input int dt);
    int n, rc, lc;
    logic done;
    send(k, a, b, 1'b0);
    rc = -1;
    lc = -1;
    n = 0;
    while (lc < 0 && n < 16) begin
      @(posedge clk);
      if (row_start === 1'b1) rc = n;
      done = (k == RF) ? ref_fire : cmd_valid;
      if (done === 1'b1) lc = n;
      n++;
    end
    check("done", 20'(lc >= 0), 20'h1);
    if (k == RF) check("banks", {4'h0, ref_banks}, ea);
    else check("addr", cmd_addr, ea);
    if (dt >= 0) begin
      check("kind", 20'(cmd_kind), 20'(k));
      check("bank", 20'(cmd_bank), 20'(b));
      check("latency", 20'(lat_start), 20'h1);
      check("row_to_data", 20'(lc - rc), 20'(dt));
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] run_time expected below 5000 seen 5000");
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("ctrl_mux", 20'(ctrl_mux), 20'h0);
    op(RD, 20'h4b3c1, 4'h3, 20'h4b3c1, 0);
    op(MS, 20'h00200, 4'h0, 20'h00200, -1);
    check("dev_mux", 20'(dev_mux), 20'h1);
    check("ctrl_mux", 20'(ctrl_mux), 20'h1);
    op(MS, 20'h00005, 4'h0, 20'h00205, -1);
    op(MS, 20'h3f105, 4'h1, 20'h00105, -1);
    send(MS, 20'h00000, 4'h3, 1'b1);
    op(MS, 20'h00001, 4'h2, 20'h00001, -1);
    // termination follows the third register write one edge late
    @(posedge clk);
    check("term_on", 20'(term_on), 20'h1);
    check("term_val", 20'(term_val), 20'h5);
    check("mr1", 20'(mr1), 20'h00105);
    check("mr2", 20'(mr2), 20'h00001);
    check("mr0", 20'(mr0), 20'h00205);
    for (int i = 0; i < 4; i++) begin
      op(i[0] ? WR : RD, addrs[i], 4'(i * 5), addrs[i], 1);
    end
    op(RF, 20'h00009, 4'h0, 20'h00009, -1);
    send(RF, 20'h00000, 4'h0, 1'b1);
    send(RF, 20'h0001f, 4'h0, 1'b1);
    op(RF, 20'h0f000, 4'h0, 20'h0f000, -1);
    mirror_cfg <= 1'b1;
    repeat (2) @(posedge clk);
    op(RD, 20'h12345, 4'h9, 20'h12345, 1);
    op(WR, 20'hedcba, 4'h6, 20'hedcba, 1);
    mirror_cfg <= 1'b0;
    repeat (2) @(posedge clk);
    op(RD, 20'h3c3c3, 4'h1, 20'h3c3c3, 1);
    op(MS, 20'h00005, 4'h1, 20'h00005, -1);
    op(RF, 20'h0ffff, 4'h6, 20'h00040, -1);
    send(mxac_pkg::MXAC_NOP, 20'h00000, 4'h0, 1'b1);
    op(MS, 20'h00200, 4'h0, 20'h00200, -1);
    send(MS, 20'h00001, 4'h2, 1'b1);
    // burst eight stays legal on the narrow part; top two address bits are not carried
    op(MS, 20'h00010, 4'h1, 20'h00010, -1);
    op(RD, 20'hfffff, 4'h2, 20'h3ffff, 1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("mr0_after_reset", 20'(mr0), 20'h00000);
    check("dev_mux_after_reset", 20'(dev_mux), 20'h0);
    complete_run();
  end
endmodule // muxed_address_command_port_tb
